// *** hw/hyp_trap_pkg.sv ***
package hyp_trap_pkg;
  // exception levels as seen on the decode and register ports
  localparam logic [1:0] LVL_USER = 2'h0;
  localparam logic [1:0] LVL_OS = 2'h1;
  localparam logic [1:0] LVL_HYP = 2'h2;

  // kind of exception handed to exception entry, gray along none -> trap -> undef
  typedef enum logic [1:0] {
    EXC_NONE = 2'h0,
    EXC_HYP_TRAP = 2'h1,
    EXC_UNDEF = 2'h3
  } exc_kind_t;

  // feature-trap register field positions
  localparam int FT_ACCESS_CTL_BIT = 31;
  localparam int FT_TRACE_BIT = 20;
  localparam int FT_VECTOR_BIT = 15;
  localparam int FT_FP_SHADOW_BIT = 11;
  localparam int FT_FP_BIT = 10;
  // bits 13:12 and 9:0 always read as one
  localparam logic [31:0] FT_RES1_MASK = 32'h0000_33ff;
  localparam logic [31:0] FT_RESET = 32'h0000_0000;

  // configuration register upper byte, positions relative to bit 24
  localparam int CFG_LSB = 24;
  localparam int CFG_MEMRD_BIT = 6;
  localparam int CFG_HCALL_BIT = 5;
  localparam int CFG_ROUTE_BIT = 3;
  localparam int CFG_MEMWR_BIT = 2;
  localparam int CFG_POU_BIT = 0;
  localparam logic [7:0] CFG_RW_MASK = 8'h6d;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // coprocessor move encodings of both registers
  localparam logic [3:0] ENC_COPROC = 4'hf;
  localparam logic [2:0] ENC_OPC1 = 3'h4;
  localparam logic [3:0] ENC_CRN = 4'h1;
  localparam logic [3:0] ENC_CRM = 4'h1;
  localparam logic [2:0] ENC_FT_OPC2 = 3'h2;
  localparam logic [2:0] ENC_CFG_OPC2 = 3'h0;
endpackage : hyp_trap_pkg

// *** hw/hyp_trap_controls.sv ***
// Functional notes
// - access-control register trap sends OS accesses to hypervisor
// - trace trap sends trace sysreg accesses to hypervisor
// - trap from user/OS, undefined when from hypervisor
// - trapped access commits no side effects
// - external debug trace accesses never trapped
// - vector trap only while fp trap clear
// - vector bit reads as one when absent
// - shadow fp bit has no trapping effect
// - fp trap covers fp, vector, register accesses
// - no fp hardware holds fp bits at one
// - writable trap fields reset to zero
// - memory-control reads from OS trap to hypervisor
// - hypercall disable makes hypercall undefined locally
// - routing bit sends OS exceptions to hypervisor
// - routing forces mmu off, overrides on
// - routing disables virtual irqs, illegal OS return
// - routing forces debug trap bits to one
// - memory-control writes from OS trap to hypervisor
// - unification cache maintenance from OS traps
// - user-level undefined beats cache maintenance trap
// - access-control traps outrank feature traps
// - feature reset values only when resetting into hypervisor
module hyp_trap_controls import hyp_trap_pkg::*; #(
  parameter bit HAS_FP = 1'b1,              // floating-point hardware present
  parameter bit HAS_VECTOR = 1'b1,          // vector hardware present
  parameter bit VECTOR_TRAP_RW = 1'b1,      // vector trap bit writable
  parameter bit TRACE_TRAP_RW = 1'b1,       // trace trap bit writable
  parameter logic [31:0] UNKNOWN_FILL = 32'h0000_0000  // warm-reset contents of feature fields
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reset_into_hyp,
  // system register move port
  input wire logic sr_valid,
  input wire logic sr_write,
  input wire logic [1:0] sr_level,
  input wire logic [3:0] sr_coproc,
  input wire logic [2:0] sr_opc1,
  input wire logic [3:0] sr_crn,
  input wire logic [3:0] sr_crm,
  input wire logic [2:0] sr_opc2,
  input wire logic [31:0] sr_wdata,
  output logic [31:0] sr_rdata,
  output logic sr_done,
  output logic sr_denied,
  // decode classification
  input wire logic dec_valid,
  input wire logic [1:0] dec_level,
  input wire logic dec_fp,
  input wire logic dec_vector,
  input wire logic dec_trace,
  input wire logic dec_trace_ext,
  input wire logic dec_trace_user_denied,
  input wire logic dec_access_ctl,
  input wire logic dec_memctl_rd,
  input wire logic dec_memctl_wr,
  input wire logic dec_pou_maint,
  input wire logic dec_hypercall,
  input wire logic dec_lower_trap,
  output logic dec_commit,
  // exception request
  output logic exc_valid,
  output exc_kind_t exc_kind,
  output logic [1:0] exc_target,
  // stored controls from neighbouring registers
  input wire logic mmu_enable,
  input wire logic fast_irq_override,
  input wire logic irq_override,
  input wire logic async_abort_override,
  input wire logic trap_debug_rom_access,
  input wire logic trap_debug_os_access,
  input wire logic trap_debug_access,
  input wire logic eret_to_os,
  // effective controls
  output logic eff_mmu_enable,
  output logic eff_fast_irq_override,
  output logic eff_irq_override,
  output logic eff_async_abort_override,
  output logic eff_trap_debug_rom_access,
  output logic eff_trap_debug_os_access,
  output logic eff_trap_debug_access,
  output logic virt_irq_enable,
  output logic eret_illegal
);

  // writable bits of the feature-trap register, shaped by the build options
  localparam logic [31:0] FT_RW_MASK = (32'h1 << FT_ACCESS_CTL_BIT)
    | (TRACE_TRAP_RW ? (32'h1 << FT_TRACE_BIT) : 32'h0)
    | ((HAS_VECTOR && VECTOR_TRAP_RW) ? (32'h1 << FT_VECTOR_BIT) : 32'h0)
    | (HAS_FP ? ((32'h1 << FT_FP_SHADOW_BIT) | (32'h1 << FT_FP_BIT)) : 32'h0);
  // bits that read as one: the reserved-one bits and those whose hardware is absent
  localparam logic [31:0] FT_FORCED_ONE = FT_RES1_MASK
    | (!HAS_VECTOR ? (32'h1 << FT_VECTOR_BIT) : 32'h0)
    | (!HAS_FP ? ((32'h1 << FT_FP_SHADOW_BIT) | (32'h1 << FT_FP_BIT)) : 32'h0);

  logic [31:0] ft_reg, ft_next;        // stored feature-trap fields
  logic [7:0] cfg_reg, cfg_next;       // stored configuration upper byte
  logic [31:0] ft_view;                // value as read and as used
  logic [31:0] rdata_reg, rdata_next;  // read data
  logic done_reg, done_next;           // access complete pulse
  logic denied_reg, denied_next;       // access from below hypervisor
  logic exc_valid_reg, exc_valid_next;
  exc_kind_t exc_kind_reg, exc_kind_next;
  logic [1:0] exc_target_reg, exc_target_next;
  logic enc_base, hit_ft, hit_cfg;     // encoding decode
  logic at_user, at_os, at_hyp;        // decode level
  logic route;                         // general exception routing
  logic vec_trap, feature_hit, memctl_hit, user_undef;

  // read view: forced-one bits win, unwritable bits read as zero
  assign ft_view = (ft_reg & FT_RW_MASK) | FT_FORCED_ONE;
  assign route = cfg_reg[CFG_ROUTE_BIT];

  // the fixed encoding selects one of the two registers
  assign enc_base = sr_coproc == ENC_COPROC && sr_opc1 == ENC_OPC1 && sr_crn == ENC_CRN && sr_crm == ENC_CRM;
  assign hit_ft = enc_base && sr_opc2 == ENC_FT_OPC2;
  assign hit_cfg = enc_base && sr_opc2 == ENC_CFG_OPC2;

  // register next values; only hypervisor accesses take effect
  always_comb begin
    ft_next = ft_reg;
    cfg_next = cfg_reg;
    rdata_next = rdata_reg;
    done_next = 1'b0;
    denied_next = 1'b0;
    if (sr_valid && (hit_ft || hit_cfg)) begin
      done_next = 1'b1;
      if (sr_level != LVL_HYP) begin
        // refused: no write and no read data change, so nothing leaks
        denied_next = 1'b1;
      end else if (sr_write) begin
        if (hit_ft) begin
          ft_next = sr_wdata & FT_RW_MASK;
        end else begin
          cfg_next = sr_wdata[31:CFG_LSB] & CFG_RW_MASK;
        end
      end else begin
        // shadow fp bit reads back what was stored, even if it differs
        rdata_next = hit_ft ? ft_view : {cfg_reg, 24'h00_0000};
      end
    end
  end

  // register storage; feature fields lose their defined reset outside hypervisor reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ft_reg <= reset_into_hyp ? FT_RESET : UNKNOWN_FILL;
      cfg_reg <= CFG_RESET;
      rdata_reg <= 32'h0000_0000;
      done_reg <= 1'b0;
      denied_reg <= 1'b0;
    end else begin
      ft_reg <= ft_next;
      cfg_reg <= cfg_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
      denied_reg <= denied_next;
    end
  end

  assign sr_rdata = rdata_reg;
  assign sr_done = done_reg;
  assign sr_denied = denied_reg;

  // level decode and trap conditions
  assign at_user = dec_level == LVL_USER;
  assign at_os = dec_level == LVL_OS;
  assign at_hyp = dec_level == LVL_HYP;
  // vector trap is ignored whenever the fp trap is set
  assign vec_trap = ft_view[FT_VECTOR_BIT] && !ft_view[FT_FP_BIT];
  // shadow bit 11 is deliberately absent here
  assign feature_hit = (dec_fp && ft_view[FT_FP_BIT])
    || (dec_vector && (vec_trap || ft_view[FT_FP_BIT]))
    || (dec_trace && !dec_trace_ext && ft_view[FT_TRACE_BIT]
        && !(at_user && dec_trace_user_denied))
    || (dec_access_ctl && at_os && ft_view[FT_ACCESS_CTL_BIT]);
  assign memctl_hit = at_os && ((dec_memctl_rd && cfg_reg[CFG_MEMRD_BIT])
    || (dec_memctl_wr && cfg_reg[CFG_MEMWR_BIT])
    || (dec_pou_maint && cfg_reg[CFG_POU_BIT]));
  // hypercalls and these maintenance ops never exist at user level
  // external debug trace accesses carry no level, so the user-level refusal skips them
  assign user_undef = at_user && (dec_hypercall || dec_pou_maint
    || (dec_trace && !dec_trace_ext && dec_trace_user_denied));

  // exception selection: one request per decode, highest priority first
  always_comb begin
    exc_kind_next = EXC_NONE;
    exc_target_next = LVL_OS;
    if (!dec_valid) begin
      exc_kind_next = EXC_NONE;
    end else if (user_undef) begin
      exc_kind_next = EXC_UNDEF;
    end else if (dec_lower_trap) begin
      // access-control traps to the OS level outrank every feature trap
      exc_kind_next = EXC_UNDEF;
    end else if (dec_hypercall && cfg_reg[CFG_HCALL_BIT]) begin
      exc_kind_next = EXC_UNDEF;
      exc_target_next = dec_level;
    end else if (feature_hit) begin
      exc_kind_next = at_hyp ? EXC_UNDEF : EXC_HYP_TRAP;
      exc_target_next = LVL_HYP;
    end else if (memctl_hit) begin
      exc_kind_next = EXC_HYP_TRAP;
      exc_target_next = LVL_HYP;
    end
    // nothing may be taken to the OS level while routing is on
    if (route && exc_target_next == LVL_OS) begin
      exc_target_next = LVL_HYP;
    end
    exc_valid_next = exc_kind_next != EXC_NONE;
  end

  // exception request register, one cycle after decode
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      exc_valid_reg <= 1'b0;
      exc_kind_reg <= EXC_NONE;
      exc_target_reg <= LVL_OS;
    end else begin
      exc_valid_reg <= exc_valid_next;
      exc_kind_reg <= exc_kind_next;
      exc_target_reg <= exc_target_next;
    end
  end

  assign exc_valid = exc_valid_reg;
  assign exc_kind = exc_kind_reg;
  assign exc_target = exc_target_reg;
  // the pipeline commits only decodes that raise nothing, so a trapped access has no side effect
  assign dec_commit = dec_valid && !exc_valid_next;

  // effective controls; stored values stay visible on direct reads elsewhere
  assign eff_mmu_enable = mmu_enable && !route;
  assign eff_fast_irq_override = fast_irq_override || route;
  assign eff_irq_override = irq_override || route;
  assign eff_async_abort_override = async_abort_override || route;
  assign eff_trap_debug_rom_access = trap_debug_rom_access || route;
  assign eff_trap_debug_os_access = trap_debug_os_access || route;
  assign eff_trap_debug_access = trap_debug_access || route;
  assign virt_irq_enable = !route;
  assign eret_illegal = eret_to_os && route;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_os_plain;
    dec_valid && at_os && !dec_lower_trap && !dec_hypercall;
  endsequence
  sequence s_taken_hyp_trap;
    exc_valid && exc_kind == EXC_HYP_TRAP && exc_target == LVL_HYP;
  endsequence

  AST_ACCESS_CTL: assert property (s_os_plain ##0 (dec_access_ctl && ft_view[FT_ACCESS_CTL_BIT])
    |=> s_taken_hyp_trap) else $error("access-control trap not raised");
  AST_HYP_UNDEF: assert property (dec_valid && at_hyp && dec_fp && ft_view[FT_FP_BIT] && !dec_lower_trap
    && !(dec_hypercall && cfg_reg[CFG_HCALL_BIT]) |=> exc_kind == EXC_UNDEF && exc_target == LVL_HYP)
    else $error("hypervisor-level fp trap not undefined");
  AST_NO_COMMIT: assert property (dec_valid && !dec_commit |=> exc_valid)
    else $error("uncommitted decode raised nothing");
  AST_EXT_TRACE: assert property (dec_valid && dec_trace_ext && !dec_fp && !dec_vector && !dec_access_ctl
    && !dec_memctl_rd && !dec_memctl_wr && !dec_pou_maint && !dec_hypercall && !dec_lower_trap |=> !exc_valid)
    else $error("external debug trace access trapped");
  AST_VEC_IGNORED: assert property (dec_valid && !at_hyp && dec_vector && ft_view[FT_FP_BIT] && !user_undef
    && !dec_lower_trap && !(dec_hypercall && cfg_reg[CFG_HCALL_BIT]) |=> s_taken_hyp_trap)
    else $error("vector not trapped with fp trap set");
  AST_NO_FP_ONES: assert property (!HAS_FP |-> ft_view[FT_FP_BIT] && ft_view[FT_FP_SHADOW_BIT])
    else $error("fp trap bits not held at one");
  AST_CFG_RESET: assert property ($fell(reset) |-> cfg_reg == CFG_RESET)
    else $error("configuration bits not reset");
  AST_MEMRD: assert property (s_os_plain ##0 (dec_memctl_rd && cfg_reg[CFG_MEMRD_BIT] && !feature_hit)
    |=> s_taken_hyp_trap) else $error("memory-control read not trapped");
  AST_HCALL: assert property (dec_valid && dec_hypercall && !at_user && !dec_lower_trap
    && cfg_reg[CFG_HCALL_BIT] && !route |=> exc_kind == EXC_UNDEF && exc_target == $past(dec_level))
    else $error("disabled hypercall not undefined at its level");
  AST_ROUTE: assert property (route && exc_valid_next |=> exc_target == LVL_HYP)
    else $error("exception taken to OS while routing");
  AST_ROUTE_EFF: assert property (route |-> !eff_mmu_enable && eff_irq_override && !virt_irq_enable
    && eff_trap_debug_access) else $error("routing overrides not applied");
  AST_USER_FIRST: assert property (dec_valid && at_user && dec_pou_maint |=> exc_kind == EXC_UNDEF)
    else $error("user undefined lost to maintenance trap");
  AST_LOWER_FIRST: assert property (dec_valid && dec_lower_trap && !user_undef
    |=> exc_kind == EXC_UNDEF && exc_target == (route ? LVL_HYP : LVL_OS))
    else $error("feature trap outranked access control");

endmodule : hyp_trap_controls

// *** tb/pipe_model.sv ***
// pipeline side that issues coprocessor moves to the trap registers
module pipe_model import hyp_trap_pkg::*; (
  // clock
  input wire logic clk_sys,
  // move request
  output logic sr_valid,
  output logic sr_write,
  output logic [1:0] sr_level,
  output logic [3:0] sr_coproc,
  output logic [2:0] sr_opc1,
  output logic [3:0] sr_crn,
  output logic [3:0] sr_crm,
  output logic [2:0] sr_opc2,
  output logic [31:0] sr_wdata,
  // move answer
  input wire logic [31:0] sr_rdata,
  input wire logic sr_done,
  input wire logic sr_denied
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle values at time zero
  initial begin
    sr_valid = 1'b0;
    sr_write = 1'b0;
    sr_level = LVL_HYP;
    sr_coproc = ENC_COPROC;
    sr_opc1 = ENC_OPC1;
    sr_crn = ENC_CRN;
    sr_crm = ENC_CRM;
    sr_opc2 = ENC_FT_OPC2;
    sr_wdata = 32'h0;
  end

  // one move, a single-cycle pulse; the answer is sampled one cycle later
  task automatic move(input logic wr, input logic [1:0] lvl, input logic [2:0] opc2, input logic [31:0] wd,
                      output logic [31:0] rd, output logic done, output logic den);
    @(negedge clk_sys);
    sr_valid = 1'b1;
    sr_write = wr;
    sr_level = lvl;
    sr_coproc = ENC_COPROC;
    sr_opc1 = ENC_OPC1;
    sr_crn = ENC_CRN;
    sr_crm = ENC_CRM;
    sr_opc2 = opc2;
    sr_wdata = wd;
    @(negedge clk_sys);
    done = sr_done;
    den = sr_denied;
    rd = sr_rdata;
    sr_valid = 1'b0;
    // released data must not look like the last word
    sr_wdata = ~wd;
  endtask : move
endmodule : pipe_model

// *** tb/hyp_trap_controls_tb.sv ***
// top bench: register moves through the pipeline model, decode slots driven here
module hyp_trap_controls_tb import hyp_trap_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  // decode class flags, one bit each
  localparam logic [10:0] FP = 11'h001, VEC = 11'h002, TRC = 11'h004, TEXT = 11'h008, TDEN = 11'h010;
  localparam logic [10:0] ACC = 11'h020, MRD = 11'h040, MWR = 11'h080, POU = 11'h100, HCALL = 11'h200;
  localparam logic [10:0] LOW = 11'h400;

  logic clk_sys, reset, reset_into_hyp;
  logic sr_valid, sr_write, sr_done, sr_denied;
  logic [1:0] sr_level;
  logic [3:0] sr_coproc, sr_crn, sr_crm;
  logic [2:0] sr_opc1, sr_opc2;
  logic [31:0] sr_wdata, sr_rdata;
  logic dec_valid, dec_commit, exc_valid;
  logic [1:0] dec_level, exc_target;
  exc_kind_t exc_kind;
  logic [10:0] dflags; // decode class flags
  logic [7:0] nctl; // stored neighbour controls
  logic [8:0] eff; // effective controls seen
  int failures, n_compared;

  // warm reset fill of all ones makes an unknown-reset path visible
  hyp_trap_controls #(.UNKNOWN_FILL(32'hffff_ffff)) hyp_trap_controls_inst (
    .clk_sys(clk_sys), .reset(reset), .reset_into_hyp(reset_into_hyp),
    .sr_valid(sr_valid), .sr_write(sr_write), .sr_level(sr_level), .sr_coproc(sr_coproc), .sr_opc1(sr_opc1),
    .sr_crn(sr_crn), .sr_crm(sr_crm), .sr_opc2(sr_opc2), .sr_wdata(sr_wdata), .sr_rdata(sr_rdata),
    .sr_done(sr_done), .sr_denied(sr_denied), .dec_valid(dec_valid), .dec_level(dec_level),
    .dec_fp(dflags[0]), .dec_vector(dflags[1]), .dec_trace(dflags[2]), .dec_trace_ext(dflags[3]),
    .dec_trace_user_denied(dflags[4]), .dec_access_ctl(dflags[5]), .dec_memctl_rd(dflags[6]),
    .dec_memctl_wr(dflags[7]), .dec_pou_maint(dflags[8]), .dec_hypercall(dflags[9]), .dec_lower_trap(dflags[10]),
    .dec_commit(dec_commit), .exc_valid(exc_valid), .exc_kind(exc_kind), .exc_target(exc_target),
    .mmu_enable(nctl[7]), .fast_irq_override(nctl[6]), .irq_override(nctl[5]), .async_abort_override(nctl[4]),
    .trap_debug_rom_access(nctl[3]), .trap_debug_os_access(nctl[2]), .trap_debug_access(nctl[1]),
    .eret_to_os(nctl[0]), .eff_mmu_enable(eff[8]), .eff_fast_irq_override(eff[7]), .eff_irq_override(eff[6]),
    .eff_async_abort_override(eff[5]), .eff_trap_debug_rom_access(eff[4]), .eff_trap_debug_os_access(eff[3]),
    .eff_trap_debug_access(eff[2]), .virt_irq_enable(eff[1]), .eret_illegal(eff[0])
  );

  pipe_model pipe_model_inst (
    .clk_sys(clk_sys), .sr_valid(sr_valid), .sr_write(sr_write), .sr_level(sr_level), .sr_coproc(sr_coproc),
    .sr_opc1(sr_opc1), .sr_crn(sr_crn), .sr_crm(sr_crm), .sr_opc2(sr_opc2), .sr_wdata(sr_wdata),
    .sr_rdata(sr_rdata), .sr_done(sr_done), .sr_denied(sr_denied)
  );

  // 100 ns core clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // single comparison point
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // register move; read data only judged on reads
  task automatic acc(input logic wr, input logic [1:0] lvl, input logic [2:0] opc2, input logic [31:0] wd,
                     input logic [31:0] exp_rd, input logic exp_done, input logic exp_den);
    logic [31:0] rd;
    logic done, den;
    pipe_model_inst.move(wr, lvl, opc2, wd, rd, done, den);
    chk(done, exp_done, "move done");
    chk(den, exp_den, "move denied");
    if (!wr) begin
      chk(rd, exp_rd, "read data");
    end
  endtask : acc

  // one decode slot; commit now, exception request one cycle later
  task automatic dtest(input logic [1:0] lvl, input logic [10:0] f, input logic [1:0] kind, input logic [1:0] tgt);
    @(negedge clk_sys);
    dec_valid = 1'b1;
    dec_level = lvl;
    dflags = f;
    #1;
    chk(dec_commit, kind == 2'h0, "commit");
    @(negedge clk_sys);
    dec_valid = 1'b0;
    dflags = 11'h0;
    chk(exc_valid, kind != 2'h0, "exception valid");
    chk(exc_kind, kind, "exception kind");
    if (kind != 2'h0) begin
      chk(exc_target, tgt, "exception target");
    end
  endtask : dtest

  // reset contents, write masks, refusals and an unmatched encoding
  task automatic reg_scenario();
    acc(1'b0, LVL_HYP, ENC_FT_OPC2, 32'h0, FT_RES1_MASK, 1'b1, 1'b0);
    acc(1'b0, LVL_HYP, ENC_CFG_OPC2, 32'h0, 32'h0, 1'b1, 1'b0);
    acc(1'b1, LVL_HYP, ENC_FT_OPC2, 32'hffff_ffff, 32'h0, 1'b1, 1'b0);
    acc(1'b0, LVL_HYP, ENC_FT_OPC2, 32'h0, 32'h8010_bfff, 1'b1, 1'b0);
    acc(1'b1, LVL_OS, ENC_FT_OPC2, 32'h0, 32'h0, 1'b1, 1'b1);
    acc(1'b0, LVL_HYP, ENC_FT_OPC2, 32'h0, 32'h8010_bfff, 1'b1, 1'b0);
    acc(1'b0, LVL_HYP, 3'h7, 32'h0, 32'h8010_bfff, 1'b0, 1'b0);
  endtask : reg_scenario

  // feature traps: fp covers vector, shadow bit ignored, external trace untouched
  task automatic trap_scenario();
    acc(1'b1, LVL_HYP, ENC_FT_OPC2, 32'h0000_0c00, 32'h0, 1'b1, 1'b0);
    dtest(LVL_OS, FP, 2'h1, LVL_HYP);
    dtest(LVL_HYP, FP, 2'h3, LVL_HYP);
    dtest(LVL_USER, VEC, 2'h1, LVL_HYP);
    dtest(LVL_OS, FP | LOW, 2'h3, LVL_OS);
    acc(1'b1, LVL_HYP, ENC_FT_OPC2, 32'h8010_8800, 32'h0, 1'b1, 1'b0);
    dtest(LVL_OS, VEC, 2'h1, LVL_HYP);
    dtest(LVL_OS, FP, 2'h0, LVL_OS);
    dtest(LVL_OS, TRC | TEXT, 2'h0, LVL_OS);
    dtest(LVL_USER, TRC, 2'h1, LVL_HYP);
    dtest(LVL_USER, TRC | TDEN, 2'h3, LVL_OS);
    dtest(LVL_OS, ACC, 2'h1, LVL_HYP);
    acc(1'b1, LVL_HYP, ENC_FT_OPC2, 32'h0, 32'h0, 1'b1, 1'b0);
  endtask : trap_scenario

  // configuration byte: stored bits, memory-control, hypercall and maintenance traps
  task automatic cfg_scenario();
    acc(1'b1, LVL_HYP, ENC_CFG_OPC2, 32'hffff_ffff, 32'h0, 1'b1, 1'b0);
    acc(1'b0, LVL_HYP, ENC_CFG_OPC2, 32'h0, 32'h6d00_0000, 1'b1, 1'b0);
    acc(1'b1, LVL_HYP, ENC_CFG_OPC2, 32'h6500_0000, 32'h0, 1'b1, 1'b0);
    dtest(LVL_OS, MRD, 2'h1, LVL_HYP);
    dtest(LVL_OS, MWR, 2'h1, LVL_HYP);
    dtest(LVL_OS, POU, 2'h1, LVL_HYP);
    dtest(LVL_USER, POU, 2'h3, LVL_OS);
    dtest(LVL_OS, HCALL, 2'h3, LVL_OS);
    dtest(LVL_HYP, HCALL, 2'h3, LVL_HYP);
  endtask : cfg_scenario

  // routing bit forces effective controls and redirects OS exceptions
  task automatic route_scenario();
    chk(eff, 9'h102, "effective controls");
    acc(1'b1, LVL_HYP, ENC_CFG_OPC2, 32'h0800_0000, 32'h0, 1'b1, 1'b0);
    chk(eff, 9'h0fd, "effective controls");
    dtest(LVL_OS, FP | LOW, 2'h3, LVL_HYP);
    acc(1'b1, LVL_HYP, ENC_CFG_OPC2, 32'h0, 32'h0, 1'b1, 1'b0);
  endtask : route_scenario

  // reset not into hypervisor keeps the fill value in feature fields
  task automatic warm_scenario();
    // leave configuration bits set so the reset has something to clear
    acc(1'b1, LVL_HYP, ENC_CFG_OPC2, 32'h6d00_0000, 32'h0, 1'b1, 1'b0);
    @(negedge clk_sys);
    reset = 1'b1;
    reset_into_hyp = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    acc(1'b0, LVL_HYP, ENC_FT_OPC2, 32'h0, 32'h8010_bfff, 1'b1, 1'b0);
    acc(1'b0, LVL_HYP, ENC_CFG_OPC2, 32'h0, 32'h0, 1'b1, 1'b0);
  endtask : warm_scenario

  // verdict and end of run
  task automatic stop_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    stop_test();
  end

  // main sequence
  initial begin
    failures = 0;
    n_compared = 0;
    reset = 1'b1;
    reset_into_hyp = 1'b1;
    dec_valid = 1'b0;
    dec_level = LVL_OS;
    dflags = 11'h0;
    nctl = 8'h81;
    repeat (8) @(negedge clk_sys);
    reset = 1'b0;
    reg_scenario();
    trap_scenario();
    cfg_scenario();
    route_scenario();
    warm_scenario();
    stop_test();
  end
endmodule : hyp_trap_controls_tb
